//--- rtl/pbm_pkg.sv
// Port B address / clock pin multiplexer: shared constants and carriers.
// Assumes one 50 MHz system clock and an AXI4-Lite register port.
`default_nettype none
package pbm_pkg;
    localparam int PBM_PINS = 8;
    // Register byte offsets
    localparam logic [7:0] PBM_OFS_DDR = 8'h00;
    localparam logic [7:0] PBM_OFS_DOUT = 8'h04;
    localparam logic [7:0] PBM_OFS_PER = 8'h08;
    localparam logic [7:0] PBM_OFS_PUR = 8'h0c;
    localparam logic [7:0] PBM_OFS_CLOCK_OUTPUT_SELECT = 8'h10;
    localparam logic [7:0] PBM_OFS_BCR = 8'h14;
    localparam logic [7:0] PBM_OFS_PIN = 8'h18;
    // Reset values
    localparam logic [7:0] PBM_RST_DDR = 8'h00;
    localparam logic [7:0] PBM_RST_DOUT = 8'h00;
    localparam logic [7:0] PBM_RST_PUR = 8'hff;
    localparam logic [3:0] PBM_RST_CLOCK_OUTPUT_SELECT = 4'h0;
    localparam logic PBM_RST_DRIVE = 1'b0;
    // Upper nibble of peripheral enable always resets to GPIO
    localparam logic [3:0] PBM_RST_PER_HI = 4'hf;
    // Strap settle time after reset, in cycles
    localparam logic [1:0] PBM_STRAP_WAIT = 2'h3;
    // Field positions and response codes
    localparam int PBM_BCR_DRV_BIT = 0;
    localparam logic [1:0] PBM_RESP_OKAY = 2'b00;
    localparam logic [1:0] PBM_RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pu;
    } pbm_pad_t;

    typedef struct packed {
        logic prescaler;
        logic sys_main;
        logic sys_doubled;
        logic osc;
    } pbm_clk_t;
endpackage
`default_nettype wire

//--- rtl/pbm_sync2.sv
// Two flip-flop synchroniser for one pin level.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module pbm_sync2
(
    // Clock and reset
    input wire logic system_clock_main_i,
    input wire logic rst_n_i,
    // Level
    input wire logic d_i,
    output logic q_o
);
    logic meta_q;

    always_ff @(posedge system_clock_main_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= 1'b0;
            q_o <= 1'b0;
        end
        else
        begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule
`default_nettype wire

//--- rtl/pbm_pin_cell.sv
// One port B pad cell: selects GPIO, address or clock monitor drive.
// Assumes the selection inputs are all on the system clock.
`timescale 1ns/1ps
`default_nettype none
module pbm_pin_cell
(
    // Selection
    input wire logic gpio_i,
    input wire logic use_clk_i,
    input wire logic drive_bus_i,
    // GPIO side
    input wire logic ddr_i,
    input wire logic dout_i,
    input wire logic pu_i,
    // Alternate sources
    input wire logic addr_i,
    input wire logic clk_i,
    // Pad drive
    output logic out_o,
    output logic oe_o,
    output logic pu_o
);
    wire alt_val = use_clk_i ? clk_i : addr_i;
    // GPIO ignores bus tri-state entirely
    assign out_o = gpio_i ? dout_i : alt_val;
    assign oe_o = gpio_i ? ddr_i : (use_clk_i | drive_bus_i);
    assign pu_o = pu_i;
endmodule
`default_nettype wire

//--- rtl/pbm_top.sv
// Port B pin multiplexer with AXI4-Lite control registers.
// Assumes straps are stable pins, sampled after reset release.
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pbm_top
    import pbm_pkg::*;
(
    // Clock and reset
    input wire logic system_clock_main_i,
    input wire logic rst_n_i,
    // AXI4-Lite write
    input wire logic [7:0] s_awaddr_i,
    input wire logic s_awvalid_i,
    output logic s_awready_o,
    input wire logic [31:0] s_wdata_i,
    input wire logic [3:0] s_wstrb_i,
    input wire logic s_wvalid_i,
    output logic s_wready_o,
    output logic [1:0] s_bresp_o,
    output logic s_bvalid_o,
    input wire logic s_bready_i,
    // AXI4-Lite read
    input wire logic [7:0] s_araddr_i,
    input wire logic s_arvalid_i,
    output logic s_arready_o,
    output logic [31:0] s_rdata_o,
    output logic [1:0] s_rresp_o,
    output logic s_rvalid_o,
    input wire logic s_rready_i,
    // Straps and security
    input wire logic external_boot_strap_i,
    input wire logic mem_interface_mode_strap_i,
    input wire logic flash_secure_i,
    // External memory interface
    input wire logic [7:0] upper_address_i,
    input wire logic bus_active_i,
    output logic bus_drive_select_o,
    // Clocks to monitor
    input wire pbm_clk_t mon_clk_i,
    // Pads
    input wire logic [7:0] pad_in_i,
    output pbm_pad_t pad_o
);
    ////////////////////////////////////////////////////////////////////
    logic [7:0] ddr_q, dout_q, per_q, pur_q;
    logic [3:0] clock_output_select_q;
    logic drive_q;
    logic strap_done_q;
    logic [7:0] pin_sync;
    logic boot_s, mode_s, sec_s;
    logic aw_hold_q, w_hold_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    pbm_pad_t pad_d;

    pbm_sync2 u_sync_boot (.system_clock_main_i(system_clock_main_i), .rst_n_i(rst_n_i),
        .d_i(external_boot_strap_i), .q_o(boot_s));
    pbm_sync2 u_sync_mode (.system_clock_main_i(system_clock_main_i), .rst_n_i(rst_n_i),
        .d_i(mem_interface_mode_strap_i), .q_o(mode_s));
    pbm_sync2 u_sync_sec (.system_clock_main_i(system_clock_main_i), .rst_n_i(rst_n_i),
        .d_i(flash_secure_i), .q_o(sec_s));

    genvar gi;
    generate
        for (gi = 0; gi < PBM_PINS; gi++)
        begin : g_pin
            pbm_sync2 u_sync (.system_clock_main_i(system_clock_main_i), .rst_n_i(rst_n_i),
                .d_i(pad_in_i[gi]), .q_o(pin_sync[gi]));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Strap decode: address on pins 0-3 only for external boot with
    // the interface in wide mode and flash not secured
    wire strap_addr = boot_s & mode_s & ~sec_s;
    // Straps settle through the synchroniser before being latched
    logic [1:0] strap_cnt_q;

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path
    wire aw_take = s_awvalid_i & s_awready_o;
    wire w_take = s_wvalid_i & s_wready_o;
    wire aw_have = aw_hold_q | aw_take;
    wire w_have = w_hold_q | w_take;
    wire [7:0] wr_addr = aw_hold_q ? aw_addr_q : s_awaddr_i;
    wire [31:0] wr_data = w_hold_q ? w_data_q : s_wdata_i;
    wire [3:0] wr_strb = w_hold_q ? w_strb_q : s_wstrb_i;
    wire wr_fire = aw_have & w_have & ~s_bvalid_o;
    wire aw_hold_d = aw_have & ~wr_fire;
    wire w_hold_d = w_have & ~wr_fire;
    wire bvalid_d = wr_fire | (s_bvalid_o & ~s_bready_i);
    wire wr_lane0 = wr_fire & wr_strb[0];
    wire wr_ok = (wr_addr == PBM_OFS_DDR) | (wr_addr == PBM_OFS_DOUT) |
        (wr_addr == PBM_OFS_PER) | (wr_addr == PBM_OFS_PUR) |
        (wr_addr == PBM_OFS_CLOCK_OUTPUT_SELECT) | (wr_addr == PBM_OFS_BCR) |
        (wr_addr == PBM_OFS_PIN);
    wire we_ddr = wr_lane0 & (wr_addr == PBM_OFS_DDR);
    wire we_dout = wr_lane0 & (wr_addr == PBM_OFS_DOUT);
    wire we_per = wr_lane0 & (wr_addr == PBM_OFS_PER);
    wire we_pur = wr_lane0 & (wr_addr == PBM_OFS_PUR);
    wire we_clk = wr_lane0 & (wr_addr == PBM_OFS_CLOCK_OUTPUT_SELECT);
    wire we_bcr = wr_lane0 & (wr_addr == PBM_OFS_BCR);

    always_ff @(posedge system_clock_main_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_bvalid_o <= 1'b0;
            s_awready_o <= 1'b0;
            s_wready_o <= 1'b0;
            s_bresp_o <= PBM_RESP_OKAY;
        end
        else
        begin
            if (aw_take)
                aw_addr_q <= s_awaddr_i;
            if (w_take)
            begin
                w_data_q <= s_wdata_i;
                w_strb_q <= s_wstrb_i;
            end
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            s_bvalid_o <= bvalid_d;
            // Readies from next state so every port leaves a flop
            s_awready_o <= ~aw_hold_d & ~bvalid_d;
            s_wready_o <= ~w_hold_d & ~bvalid_d;
            if (wr_fire)
                s_bresp_o <= wr_ok ? PBM_RESP_OKAY : PBM_RESP_SLVERR;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge system_clock_main_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ddr_q <= PBM_RST_DDR;
            dout_q <= PBM_RST_DOUT;
            per_q <= {PBM_RST_PER_HI, 4'hf};
            pur_q <= PBM_RST_PUR;
            clock_output_select_q <= PBM_RST_CLOCK_OUTPUT_SELECT;
            drive_q <= PBM_RST_DRIVE;
            strap_done_q <= 1'b0;
            strap_cnt_q <= 2'h0;
        end
        else
        begin
            if (we_ddr)
                ddr_q <= wr_data[7:0];
            if (we_dout)
                dout_q <= wr_data[7:0];
            if (we_pur)
                pur_q <= wr_data[7:0];
            if (we_clk)
                clock_output_select_q <= wr_data[3:0];
            if (we_bcr)
                drive_q <= wr_data[PBM_BCR_DRV_BIT];
            if (!strap_done_q)
                strap_cnt_q <= strap_cnt_q + 2'h1;
            // Software write beats a late strap latch
            if (we_per)
            begin
                per_q <= wr_data[7:0];
                strap_done_q <= 1'b1;
            end
            else if (!strap_done_q && strap_cnt_q == PBM_STRAP_WAIT)
            begin
                per_q[3:0] <= {4{~strap_addr}};
                strap_done_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path
    wire ar_take = s_arvalid_i & s_arready_o;
    wire rvalid_d = ar_take | (s_rvalid_o & ~s_rready_i);
    logic [31:0] rd_mux;
    logic rd_ok;
    always_comb
    begin
        rd_ok = 1'b1;
        case (s_araddr_i)
            PBM_OFS_DDR: rd_mux = {24'h0, ddr_q};
            PBM_OFS_DOUT: rd_mux = {24'h0, dout_q};
            PBM_OFS_PER: rd_mux = {24'h0, per_q};
            PBM_OFS_PUR: rd_mux = {24'h0, pur_q};
            PBM_OFS_CLOCK_OUTPUT_SELECT: rd_mux = {28'h0, clock_output_select_q};
            PBM_OFS_BCR: rd_mux = {31'h0, drive_q};
            PBM_OFS_PIN: rd_mux = {24'h0, pin_sync};
            default:
            begin
                rd_mux = 32'h0000_0000;
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge system_clock_main_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_rvalid_o <= 1'b0;
            s_rdata_o <= 32'h0000_0000;
            s_rresp_o <= PBM_RESP_OKAY;
            s_arready_o <= 1'b0;
        end
        else
        begin
            s_rvalid_o <= rvalid_d;
            s_arready_o <= ~rvalid_d;
            if (ar_take)
            begin
                s_rdata_o <= rd_mux;
                s_rresp_o <= rd_ok ? PBM_RESP_OKAY : PBM_RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pad cells; clocks only on pins 4-7, low pins GPIO or address only
    wire [3:0] mon_vec = {mon_clk_i.osc, mon_clk_i.sys_doubled,
        mon_clk_i.sys_main, mon_clk_i.prescaler};
    wire drive_bus = drive_q | bus_active_i;
    wire [7:0] cell_out, cell_oe, cell_pu;

    generate
        for (gi = 0; gi < PBM_PINS; gi++)
        begin : g_cell
            if (gi >= 4)
            begin : g_hi
                pbm_pin_cell u_cell (.gpio_i(per_q[gi]), .use_clk_i(clock_output_select_q[gi-4]),
                    .drive_bus_i(drive_bus), .ddr_i(ddr_q[gi]), .dout_i(dout_q[gi]),
                    .pu_i(pur_q[gi]), .addr_i(upper_address_i[gi]),
                    .clk_i(mon_vec[gi-4]), .out_o(cell_out[gi]), .oe_o(cell_oe[gi]),
                    .pu_o(cell_pu[gi]));
            end
            else
            begin : g_lo
                pbm_pin_cell u_cell (.gpio_i(per_q[gi]), .use_clk_i(1'b0),
                    .drive_bus_i(drive_bus), .ddr_i(ddr_q[gi]), .dout_i(dout_q[gi]),
                    .pu_i(pur_q[gi]), .addr_i(upper_address_i[gi]),
                    .clk_i(1'b0), .out_o(cell_out[gi]), .oe_o(cell_oe[gi]),
                    .pu_o(cell_pu[gi]));
            end
        end
    endgenerate

    // Registered pads: monitor clocks show one cycle late, sampled only;
    // a true clock mirror would need an unregistered path
    assign pad_d = '{out: cell_out, oe: cell_oe, pu: cell_pu};

    always_ff @(posedge system_clock_main_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pad_o <= '{out: 8'h00, oe: 8'h00, pu: PBM_RST_PUR};
            bus_drive_select_o <= PBM_RST_DRIVE;
        end
        else
        begin
            pad_o <= pad_d;
            bus_drive_select_o <= drive_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    a_gpio_oe_follow: assert property (@(posedge system_clock_main_i) disable iff (!rst_n_i)
        per_q[0] |=> pad_o.oe[0] == $past(ddr_q[0]))
        else $error("gpio pin oe not following direction");
    a_pullup_follow: assert property (@(posedge system_clock_main_i) disable iff (!rst_n_i)
        1'b1 |=> pad_o.pu == $past(pur_q))
        else $error("pull-up not following register");
    a_addr_tristate: assert property (@(posedge system_clock_main_i) disable iff (!rst_n_i)
        (!per_q[5] && !clock_output_select_q[1] && !drive_q && !bus_active_i) |=> !pad_o.oe[5])
        else $error("idle address pin driven");
    a_addr_driven: assert property (@(posedge system_clock_main_i) disable iff (!rst_n_i)
        (!per_q[6] && !clock_output_select_q[2] && drive_q) |=> pad_o.oe[6] &&
        pad_o.out[6] == $past(upper_address_i[6]))
        else $error("address pin not driven with address");
    a_clk_select: assert property (@(posedge system_clock_main_i) disable iff (!rst_n_i)
        (!per_q[7] && clock_output_select_q[3]) |=> pad_o.oe[7] && pad_o.out[7] == $past(mon_clk_i.osc))
        else $error("clock monitor pin wrong");
    a_gpio_out_val: assert property (@(posedge system_clock_main_i) disable iff (!rst_n_i)
        per_q[4] |=> pad_o.out[4] == $past(dout_q[4]))
        else $error("gpio output value wrong");
    a_per_write: assert property (@(posedge system_clock_main_i) disable iff (!rst_n_i)
        we_per |=> per_q == $past(wr_data[7:0]))
        else $error("peripheral enable write lost");
    a_hi_reset_gpio: assert property (@(posedge system_clock_main_i) disable iff (!rst_n_i)
        !strap_done_q |-> per_q[7:4] == 4'hf)
        else $error("upper pins not gpio after reset");
    a_strap_latch: assert property (@(posedge system_clock_main_i) disable iff (!rst_n_i)
        (!strap_done_q && strap_cnt_q == PBM_STRAP_WAIT && !we_per) |=>
        per_q[3:0] == {4{~$past(strap_addr)}})
        else $error("strap choice not latched");
endmodule
`default_nettype wire

//--- tb/pbm_mem_model.sv
// Pad load model: memory and board wiring seen by the port B pads.
// Assumes pad drive is registered on the system clock.
`timescale 1ns/1ps
`default_nettype none
module pbm_mem_model
    import pbm_pkg::*;
(
    // Clock
    input wire logic system_clock_main_i,
    // Pad drive from the block
    input wire pbm_pad_t pad_i,
    // Wire level back to the block
    output logic [7:0] level_o
);
    logic [7:0] last_q = 8'h00;
    // Floating with no pull-up toggles, so a stale level never looks valid
    assign level_o = (pad_i.oe & pad_i.out) | (~pad_i.oe & pad_i.pu)
        | (~pad_i.oe & ~pad_i.pu & ~last_q);
    always_ff @(posedge system_clock_main_i)
    begin
        last_q <= level_o;
    end
endmodule
`default_nettype wire

//--- tb/pbm_top_tb_top.sv
// Self-checking bench for the port B pin multiplexer.
// Assumes pbm_top and the pad load model; AXI4-Lite master in tasks.
`timescale 1ns/1ps
`default_nettype none
module pbm_top_tb_top
    import pbm_pkg::*;
;
    logic system_clock_main_i, rst_n_i, awv, wv, bry, arv, rry, bact, drv;
    logic boot, mode, sec;
    logic awr, wrdy, arr, bv, rv;
    logic [7:0] awa, ara, upa, lvl;
    logic [31:0] wd, rdat;
    logic [1:0] br, rr;
    pbm_clk_t mclk;
    pbm_pad_t pad;
    int bad_count = 0;
    int comparisons = 0;
    int cyc = 0;
    //////////////////////////////////////////////////////////////////
    pbm_top u_pbm_top (.system_clock_main_i(system_clock_main_i), .rst_n_i(rst_n_i),
        .s_awaddr_i(awa), .s_awvalid_i(awv), .s_awready_o(awr),
        .s_wdata_i(wd), .s_wstrb_i(4'h1), .s_wvalid_i(wv), .s_wready_o(wrdy),
        .s_bresp_o(br), .s_bvalid_o(bv), .s_bready_i(bry),
        .s_araddr_i(ara), .s_arvalid_i(arv), .s_arready_o(arr),
        .s_rdata_o(rdat), .s_rresp_o(rr), .s_rvalid_o(rv), .s_rready_i(rry),
        .external_boot_strap_i(boot), .mem_interface_mode_strap_i(mode),
        .flash_secure_i(sec), .upper_address_i(upa), .bus_active_i(bact),
        .bus_drive_select_o(drv), .mon_clk_i(mclk), .pad_in_i(lvl),
        .pad_o(pad));
    pbm_mem_model u_pbm_mem_model (.system_clock_main_i(system_clock_main_i), .pad_i(pad),
        .level_o(lvl));
    //////////////////////////////////////////////////////////////////
    initial
    begin
        system_clock_main_i = 1'b0;
        forever #10 system_clock_main_i = ~system_clock_main_i;
    end
    // Whole run needs well under a thousand cycles
    always @(posedge system_clock_main_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            bad_count++;
            complete_run;
        end
    end
    //////////////////////////////////////////////////////////////////
    task complete_run;
        $display("counts: %0d compares, %0d bad", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk_pad(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: pad %h want %h", $time, got, exp);
        end
    endtask
    task chk_rd(input logic [31:0] d, input logic [1:0] r,
        input logic [31:0] ed, input logic [1:0] er);
        comparisons++;
        if (d !== ed || r !== er)
        begin
            bad_count++;
            $display("unexpected at %0t: bus %h/%b want %h/%b", $time, d, r, ed, er);
        end
    endtask
    task settle(input int n);
        repeat (n) @(posedge system_clock_main_i);
        @(negedge system_clock_main_i);
    endtask
    // Valid and payload stay put until sampled with ready at a rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ta, tw, done;
        logic [1:0] r;
        done = 1'b0;
        @(posedge system_clock_main_i);
        awa <= a;
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        while (!done)
        begin
            @(negedge system_clock_main_i);
            ta = awv && awr;
            tw = wv && wrdy;
            done = bv;
            r = br;
            @(posedge system_clock_main_i);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end
        bry <= 1'b0;
        chk_rd(32'h0, r, 32'h0, er);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ta, done;
        logic [1:0] r;
        logic [31:0] d;
        done = 1'b0;
        @(posedge system_clock_main_i);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        while (!done)
        begin
            @(negedge system_clock_main_i);
            ta = arv && arr;
            done = rv;
            r = rr;
            d = rdat;
            @(posedge system_clock_main_i);
            if (ta) arv <= 1'b0;
        end
        rry <= 1'b0;
        chk_rd(d, r, ed, er);
    endtask
    //////////////////////////////////////////////////////////////////
    task t_reset;
        rd(PBM_OFS_PER, 32'hf0, PBM_RESP_OKAY);
        rd(PBM_OFS_PUR, 32'hff, PBM_RESP_OKAY);
        settle(1);
        chk_pad(pad.oe, 8'h00);
        chk_pad(pad.pu, 8'hff);
        chk_pad({7'h0, drv}, 8'h00);
        $display("test reset done");
    endtask
    task t_gpio;
        wr(PBM_OFS_PER, 8'hff, PBM_RESP_OKAY);
        wr(PBM_OFS_DDR, 8'h0f, PBM_RESP_OKAY);
        wr(PBM_OFS_DOUT, 8'h0a, PBM_RESP_OKAY);
        settle(3);
        chk_pad(pad.oe, 8'h0f);
        chk_pad(pad.out, 8'h0a);
        settle(4);
        rd(PBM_OFS_PIN, 32'hfa, PBM_RESP_OKAY);
        $display("test gpio done");
    endtask
    task t_addr;
        @(posedge system_clock_main_i);
        upa <= 8'ha5;
        wr(PBM_OFS_PER, 8'hfe, PBM_RESP_OKAY);
        settle(3);
        chk_pad(pad.oe, 8'h0e);
        @(posedge system_clock_main_i);
        bact <= 1'b1;
        settle(3);
        chk_pad(pad.oe, 8'h0f);
        chk_pad(pad.out, 8'h0b);
        @(posedge system_clock_main_i);
        bact <= 1'b0;
        wr(PBM_OFS_BCR, 8'h01, PBM_RESP_OKAY);
        settle(3);
        chk_pad(pad.oe, 8'h0f);
        chk_pad({7'h0, drv}, 8'h01);
        wr(PBM_OFS_BCR, 8'h00, PBM_RESP_OKAY);
        $display("test address done");
    endtask
    task t_upper;
        wr(PBM_OFS_PER, 8'h0f, PBM_RESP_OKAY);
        @(posedge system_clock_main_i);
        bact <= 1'b1;
        settle(3);
        chk_pad(pad.out, 8'haa);
        chk_pad(pad.oe, 8'hff);
        @(posedge system_clock_main_i);
        bact <= 1'b0;
        wr(PBM_OFS_CLOCK_OUTPUT_SELECT, 8'h0f, PBM_RESP_OKAY);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge system_clock_main_i);
            mclk <= 4'b1000 >> i;
            settle(3);
            chk_pad(pad.out, {4'h1 << i, 4'ha});
            chk_pad(pad.oe, 8'hff);
        end
        $display("test clocks done");
    endtask
    task t_pull;
        wr(PBM_OFS_PUR, 8'h00, PBM_RESP_OKAY);
        settle(3);
        chk_pad(pad.pu, 8'h00);
        wr(PBM_OFS_PUR, 8'h3c, PBM_RESP_OKAY);
        settle(3);
        chk_pad(pad.pu, 8'h3c);
        $display("test pullup done");
    endtask
    task t_bad;
        rd(8'h1c, 32'h0, PBM_RESP_SLVERR);
        wr(8'h1c, 8'h55, PBM_RESP_SLVERR);
        $display("test unmapped done");
    endtask
    // Mid-run resets: secured straps give GPIO, an early write beats the straps
    task t_strap;
        @(posedge system_clock_main_i);
        rst_n_i <= 1'b0;
        sec <= 1'b1;
        repeat (5) @(posedge system_clock_main_i);
        rst_n_i <= 1'b1;
        repeat (8) @(posedge system_clock_main_i);
        rd(PBM_OFS_PER, 32'hff, PBM_RESP_OKAY);
        chk_pad({7'h0, drv}, 8'h00);
        @(posedge system_clock_main_i);
        rst_n_i <= 1'b0;
        sec <= 1'b0;
        repeat (5) @(posedge system_clock_main_i);
        rst_n_i <= 1'b1;
        wr(PBM_OFS_PER, 8'h5f, PBM_RESP_OKAY);
        repeat (8) @(posedge system_clock_main_i);
        rd(PBM_OFS_PER, 32'h5f, PBM_RESP_OKAY);
        $display("test strap done");
    endtask
    //////////////////////////////////////////////////////////////////
    initial
    begin
        rst_n_i = 1'b0;
        {awv, wv, bry, arv, rry, bact} = 6'h00;
        {boot, mode, sec} = 3'b110;
        {awa, ara, upa, wd} = 56'h0;
        mclk = 4'h0;
        repeat (5) @(posedge system_clock_main_i);
        rst_n_i <= 1'b1;
        // Let the straps land in the enable register first
        repeat (8) @(posedge system_clock_main_i);
        t_reset;
        t_gpio;
        t_addr;
        t_upper;
        t_pull;
        t_bad;
        t_strap;
        complete_run;
    end
endmodule
`default_nettype wire
